// *** hw/uiq_ctrl.sv ***
// Interrupt identification read-back and queue flush / enable command logic with APB slave
//
// Function
// - Read returns highest-priority pending interrupt code.
// - Bit 2 write flushes transmit queue control.
// - Bit 1 write flushes receive queue control.
// - Flush commands clear themselves automatically.
// - Bit 0 enables or disables both queues.
// - Changing enable bit flushes both queues.
`timescale 1ns/1ps
module uiq_ctrl (
  input wire logic clock, // 200 MHz register clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high is write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready, always one
  output logic pslverr, // APB error on unmapped address
  input wire logic line_stat_pend, // Receiver line status pending
  input wire logic rx_data_pend, // Received data available pending
  input wire logic char_tmo_pend, // Character timeout pending
  input wire logic thr_empty_pend, // Transmit holding slot empty pending
  input wire logic busy_pend, // Busy detect pending
  output logic tx_queue_flush, // One-cycle transmit queue control reset
  output logic rx_queue_flush, // One-cycle receive queue control reset
  output logic queue_enable, // Queues enabled level
  output logic irq // Level interrupt, unmasked status set
);
  import uiq_pkg::*;

  logic tx_flush_r, tx_flush_nxt;
  logic rx_flush_r, rx_flush_nxt;
  logic queue_on_r, queue_on_nxt;
  logic [UIQ_NUM_EV-1:0] stat_r, stat_nxt;
  logic [UIQ_NUM_EV-1:0] mask_r, mask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [3:0] id_code;
  logic wr_acc, rd_acc, id_wr, mapped;

  // Address decode shared by read and write paths
  function automatic logic is_mapped(input logic [11:0] a);
    return (a == UIQ_OFS_ID_CTRL) || (a == UIQ_OFS_STAT) ||
           (a == UIQ_OFS_MASK) || (a == UIQ_OFS_CTRL_RB);
  endfunction : is_mapped

  // Zero-wait slave; error only flagged in the access phase
  assign mapped = is_mapped(paddr);
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign id_wr = wr_acc && (paddr == UIQ_OFS_ID_CTRL);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Priority encoder; rx data and timeout share a level, timeout reported first
  always_comb begin
    if (line_stat_pend) id_code = UIQ_ID_LINE_STAT;
    else if (char_tmo_pend) id_code = UIQ_ID_CHAR_TMO;
    else if (rx_data_pend) id_code = UIQ_ID_RX_DATA;
    else if (thr_empty_pend) id_code = UIQ_ID_THR_EMPTY;
    else if (busy_pend) id_code = UIQ_ID_BUSY;
    else id_code = UIQ_ID_NONE;
  end

  // Command next state; flush pulses last exactly one cycle so no clear write is needed
  always_comb begin
    logic chg;
    chg = 1'b0;
    queue_on_nxt = queue_on_r;
    tx_flush_nxt = 1'b0;
    rx_flush_nxt = 1'b0;
    if (id_wr) begin
      queue_on_nxt = pwdata[UIQ_BIT_QUEUE_ON];
      chg = pwdata[UIQ_BIT_QUEUE_ON] != queue_on_r;
      tx_flush_nxt = pwdata[UIQ_BIT_TX_FLUSH] || chg;
      rx_flush_nxt = pwdata[UIQ_BIT_RX_FLUSH] || chg;
    end
    // Sticky events: a new set wins over a same-cycle write-one clear
    stat_nxt = stat_r;
    mask_nxt = mask_r;
    if (wr_acc && paddr == UIQ_OFS_STAT) stat_nxt = stat_r & ~pwdata[UIQ_NUM_EV-1:0];
    if (wr_acc && paddr == UIQ_OFS_MASK) mask_nxt = pwdata[UIQ_NUM_EV-1:0];
    stat_nxt[UIQ_ST_TX_FLUSH] = stat_nxt[UIQ_ST_TX_FLUSH] | tx_flush_nxt;
    stat_nxt[UIQ_ST_RX_FLUSH] = stat_nxt[UIQ_ST_RX_FLUSH] | rx_flush_nxt;
    stat_nxt[UIQ_ST_QUEUE_CHG] = stat_nxt[UIQ_ST_QUEUE_CHG] | chg;
  end

  // Read mux; data registered so it is valid in the access phase after setup
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        UIQ_OFS_ID_CTRL: rdata_nxt[3:0] = id_code;
        UIQ_OFS_STAT: rdata_nxt[UIQ_NUM_EV-1:0] = stat_r;
        UIQ_OFS_MASK: rdata_nxt[UIQ_NUM_EV-1:0] = mask_r;
        UIQ_OFS_CTRL_RB: rdata_nxt[0] = queue_on_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end else if (rd_acc) begin
      rdata_nxt = rdata_r;
    end
  end

  // State registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_flush_r <= 1'b0;
      rx_flush_r <= 1'b0;
      queue_on_r <= UIQ_RST_QUEUE_ON;
      stat_r <= '0;
      mask_r <= UIQ_RST_MASK;
      rdata_r <= 32'h0000_0000;
    end else begin
      tx_flush_r <= tx_flush_nxt;
      rx_flush_r <= rx_flush_nxt;
      queue_on_r <= queue_on_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign prdata = rdata_r;
  assign tx_queue_flush = tx_flush_r;
  assign rx_queue_flush = rx_flush_r;
  assign queue_enable = queue_on_r;
  assign irq = |(stat_r & mask_r);

  // Checks
  sequence s_tx_cmd;
    id_wr && pwdata[UIQ_BIT_TX_FLUSH];
  endsequence
  property p_tx_flush;
    @(posedge clock) disable iff (rst) s_tx_cmd |=> tx_queue_flush;
  endproperty
  a_tx_flush: assert property (p_tx_flush) else $error("tx flush missing");
  property p_rx_flush;
    @(posedge clock) disable iff (rst) id_wr && pwdata[UIQ_BIT_RX_FLUSH] |=> rx_queue_flush;
  endproperty
  a_rx_flush: assert property (p_rx_flush) else $error("rx flush missing");
  property p_self_clear;
    @(posedge clock) disable iff (rst) tx_queue_flush && !id_wr |=> !tx_queue_flush;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("flush not self clearing");
  property p_rx_self_clear;
    @(posedge clock) disable iff (rst) rx_queue_flush && !id_wr |=> !rx_queue_flush;
  endproperty
  a_rx_self_clear: assert property (p_rx_self_clear) else $error("rx flush stuck");
  property p_enable;
    @(posedge clock) disable iff (rst) id_wr |=> queue_enable == $past(pwdata[0]);
  endproperty
  a_enable: assert property (p_enable) else $error("enable not written");
  property p_change;
    @(posedge clock) disable iff (rst)
      $changed(queue_enable) |-> tx_queue_flush && rx_queue_flush;
  endproperty
  a_change: assert property (p_change) else $error("enable change without flush");
  property p_prio;
    @(posedge clock) disable iff (rst) line_stat_pend |-> id_code == UIQ_ID_LINE_STAT;
  endproperty
  a_prio: assert property (p_prio) else $error("line status not first");
  property p_none;
    @(posedge clock) disable iff (rst)
      !(line_stat_pend || rx_data_pend || char_tmo_pend || thr_empty_pend || busy_pend)
      |-> id_code == UIQ_ID_NONE;
  endproperty
  a_none: assert property (p_none) else $error("bad idle code");
  property p_read;
    @(posedge clock) disable iff (rst)
      psel && !penable && !pwrite && paddr == UIQ_OFS_ID_CTRL |=> prdata[3:0] == $past(id_code);
  endproperty
  a_read: assert property (p_read) else $error("read code wrong");

  // Remaining priority levels; each lower source must yield to every higher one
  property p_prio_tmo;
    @(posedge clock) disable iff (rst)
      !line_stat_pend && char_tmo_pend |-> id_code == UIQ_ID_CHAR_TMO;
  endproperty
  a_prio_tmo: assert property (p_prio_tmo) else $error("timeout not second");
  property p_prio_rx;
    @(posedge clock) disable iff (rst)
      !line_stat_pend && !char_tmo_pend && rx_data_pend |-> id_code == UIQ_ID_RX_DATA;
  endproperty
  a_prio_rx: assert property (p_prio_rx) else $error("rx data code wrong");
  property p_prio_thr;
    @(posedge clock) disable iff (rst)
      !line_stat_pend && !char_tmo_pend && !rx_data_pend && thr_empty_pend
      |-> id_code == UIQ_ID_THR_EMPTY;
  endproperty
  a_prio_thr: assert property (p_prio_thr) else $error("holding empty code wrong");
  property p_prio_busy;
    @(posedge clock) disable iff (rst)
      !line_stat_pend && !char_tmo_pend && !rx_data_pend && !thr_empty_pend && busy_pend
      |-> id_code == UIQ_ID_BUSY;
  endproperty
  a_prio_busy: assert property (p_prio_busy) else $error("busy code wrong");

  // A flush pulse with no command write behind it would drop queued data unasked
  property p_tx_cause;
    @(posedge clock) disable iff (rst) tx_queue_flush |-> $past(id_wr);
  endproperty
  a_tx_cause: assert property (p_tx_cause) else $error("tx flush without command");
  property p_rx_cause;
    @(posedge clock) disable iff (rst) rx_queue_flush |-> $past(id_wr);
  endproperty
  a_rx_cause: assert property (p_rx_cause) else $error("rx flush without command");

  // An enable toggle must flush both queues even when no flush bit is written
  sequence s_en_toggle;
    id_wr && (pwdata[UIQ_BIT_QUEUE_ON] != queue_enable);
  endsequence
  property p_toggle_flush;
    @(posedge clock) disable iff (rst) s_en_toggle |=> tx_queue_flush && rx_queue_flush;
  endproperty
  a_toggle_flush: assert property (p_toggle_flush) else $error("toggle did not flush");
  property p_enable_hold;
    @(posedge clock) disable iff (rst) !id_wr |=> $stable(queue_enable);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enable moved unasked");
endmodule : uiq_ctrl

// *** hw/uiq_pkg.sv ***
// Package with offsets, fields, codes and reset values for the interrupt id / queue control block
package uiq_pkg;
  // Register byte offsets
  localparam logic [11:0] UIQ_OFS_ID_CTRL = 12'h000; // Read: pending_irq_code, write: commands
  localparam logic [11:0] UIQ_OFS_STAT = 12'h004; // Sticky event status, write one to clear
  localparam logic [11:0] UIQ_OFS_MASK = 12'h008; // Interrupt mask, one enables
  localparam logic [11:0] UIQ_OFS_CTRL_RB = 12'h00C; // Readback of queue_enable
  // Command field positions in the write of the id / control register
  localparam int UIQ_BIT_QUEUE_ON = 0;
  localparam int UIQ_BIT_RX_FLUSH = 1;
  localparam int UIQ_BIT_TX_FLUSH = 2;
  // Reset values
  localparam logic UIQ_RST_QUEUE_ON = 1'h1;
  localparam logic [2:0] UIQ_RST_MASK = 3'h0;
  // Status bit positions
  localparam int UIQ_ST_TX_FLUSH = 0;
  localparam int UIQ_ST_RX_FLUSH = 1;
  localparam int UIQ_ST_QUEUE_CHG = 2;
  localparam int UIQ_NUM_EV = 3;
  // Interrupt identification codes
  localparam logic [3:0] UIQ_ID_NONE = 4'h1;
  localparam logic [3:0] UIQ_ID_THR_EMPTY = 4'h2;
  localparam logic [3:0] UIQ_ID_RX_DATA = 4'h4;
  localparam logic [3:0] UIQ_ID_LINE_STAT = 4'h6;
  localparam logic [3:0] UIQ_ID_BUSY = 4'h7;
  localparam logic [3:0] UIQ_ID_CHAR_TMO = 4'hC;
endpackage : uiq_pkg

// *** verification/tb.sv ***
// Self-checking bench for the interrupt id and queue command block
`timescale 1ns/1ps
module tb;
  import uiq_pkg::*;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ls, rx, ct, te, bz, txf, rxf, qen;
  integer err_count = 0, samples_checked = 0, seed = 32'h5b44, exp_en = 1, exp_stat = 0, i;

  uiq_ctrl i_uiq_ctrl (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_stat_pend(ls), .rx_data_pend(rx), .char_tmo_pend(ct),
    .thr_empty_pend(te), .busy_pend(bz), .tx_queue_flush(txf), .rx_queue_flush(rxf),
    .queue_enable(qen), .irq(irq));

  // Clock of 5 ns period
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One APB transfer; waits on pready with a bound so a stuck slave ends the run
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic err_exp);
    integer n;
    @(posedge clock);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      print_verdict();
    end
    rd = prdata;
    check("pslverr", {31'h0, err_exp}, {31'h0, pslverr});
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // Command write; the model predicts flushes from the written bits and the enable change
  task automatic wcmd(input logic [31:0] d);
    integer chg;
    chg = (d[0] != exp_en);
    apb(1'b1, UIQ_OFS_ID_CTRL, d, 1'b0);
    exp_en = d[0];
    exp_stat = exp_stat | (d[2] | chg) | ((d[1] | chg) << 1) | (chg << 2);
    #1;
    check("tx_queue_flush", d[2] | chg, {31'h0, txf});
    check("rx_queue_flush", d[1] | chg, {31'h0, rxf});
    check("queue_enable", exp_en, {31'h0, qen});
    @(posedge clock);
    #1;
    check("flush_clear", 0, {30'h0, txf, rxf});
  endtask : wcmd

  // Model of the reported code, highest priority first
  function automatic logic [31:0] exp_code();
    if (ls) return UIQ_ID_LINE_STAT;
    if (ct) return UIQ_ID_CHAR_TMO;
    if (rx) return UIQ_ID_RX_DATA;
    if (te) return UIQ_ID_THR_EMPTY;
    if (bz) return UIQ_ID_BUSY;
    return UIQ_ID_NONE;
  endfunction : exp_code

  // Main sequence
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    {ls, rx, ct, te, bz} = 5'h00;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    #1;
    check("queue_enable_rst", 1, {31'h0, qen});
    check("irq_rst", 0, {31'h0, irq});
    apb(1'b0, UIQ_OFS_MASK, 32'h0, 1'b0);
    check("mask_rst", 0, rd);
    // Random pending sets, the first one empty
    for (i = 0; i < 40; i++) begin
      @(posedge clock);
      {ls, rx, ct, te, bz} <= (i == 0) ? 5'h00 : 5'($random(seed));
      apb(1'b0, UIQ_OFS_ID_CTRL, 32'h0, 1'b0);
      check("pending_irq_code", exp_code(), rd);
    end
    // Flush singly, together, then enable changes and a repeat without change
    wcmd(32'h5);
    wcmd(32'h3);
    wcmd(32'h7);
    wcmd(32'h0);
    wcmd(32'h0);
    wcmd(32'h6);
    wcmd(32'h1);
    apb(1'b0, UIQ_OFS_CTRL_RB, 32'h0, 1'b0);
    check("enable_readback", exp_en, rd);
    // Sticky events: masked, unmasked, partial clear, full clear
    apb(1'b0, UIQ_OFS_STAT, 32'h0, 1'b0);
    check("status", exp_stat, rd);
    check("irq_masked", 0, {31'h0, irq});
    apb(1'b1, UIQ_OFS_MASK, 32'h7, 1'b0);
    #1 check("irq_on", 1, {31'h0, irq});
    apb(1'b1, UIQ_OFS_STAT, 32'h3, 1'b0);
    apb(1'b1, UIQ_OFS_MASK, 32'h3, 1'b0);
    #1 check("irq_partial", 0, {31'h0, irq});
    apb(1'b1, UIQ_OFS_STAT, 32'h4, 1'b0);
    apb(1'b0, UIQ_OFS_STAT, 32'h0, 1'b0);
    check("status_clear", 0, rd);
    // Unmapped place refuses both directions
    apb(1'b1, 12'h010, 32'hFF, 1'b1);
    apb(1'b0, 12'h010, 32'h0, 1'b1);
    check("unmapped_read", 0, rd);
    print_verdict();
  end
endmodule : tb
